// File: adf_device.sv
// Converter end: FIFOs, sample pacing, default substitution and requests
module adf_device #(
    parameter int CLKS_PER_SAMPLE = adf_pkg::CONV_CLKS_PER_SAMPLE,
    parameter int DEPTH = adf_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST_B,
    // Link to writer
    adf_if.device LINK,
    // Configuration
    input wire logic MODULE_ENABLE,
    input wire logic [adf_pkg::DIV_W-1:0] CLOCK_DIVIDE_FIELD,
    input wire logic LEFT_IRQ_TYPE_SEL,
    input wire logic RIGHT_IRQ_TYPE_SEL,
    input wire logic DATA_FORMAT_SIGNED,
    input wire logic [15:0] DEFAULT_SAMPLE,
    // Converter-side outputs
    output logic [15:0] CHANNEL_STATUS,
    output logic [15:0] LEFT_SAMPLE,
    output logic [15:0] RIGHT_SAMPLE,
    output logic SAMPLE_VALID,
    output logic LEFT_SAMPLE_SIGNED
);
    localparam int SW = adf_pkg::SAMPLE_W;
    localparam int CW = $clog2(CLKS_PER_SAMPLE);
    logic [adf_pkg::DIV_W-1:0] div_q;
    logic conv_tick;
    logic [CW-1:0] phase_q;
    logic sample_now;
    logic l_full;
    logic l_empty;
    logic r_full;
    logic r_empty;
    logic [SW-1:0] l_head;
    logic [SW-1:0] r_head;
    logic l_push;
    logic r_push;
    logic en_q;
    logic enable_rise;
    logic l_req_q;
    logic r_req_q;
    logic eval_q;

    // Status word from the four FIFO flags; all other bits read as zero
    function automatic logic [15:0] status_word(
        input logic left_full,
        input logic left_empty,
        input logic right_full,
        input logic right_empty
    );
        logic [15:0] word;
        word = 16'h0000;
        word[adf_pkg::STAT_LEFT_FULL_BIT] = left_full;
        word[adf_pkg::STAT_LEFT_EMPTY_BIT] = left_empty;
        word[adf_pkg::STAT_RIGHT_FULL_BIT] = right_full;
        word[adf_pkg::STAT_RIGHT_EMPTY_BIT] = right_empty;
        return word;
    endfunction

    // A write is ours only when its address matches and the FIFO can take it
    function automatic logic accepts(
        input logic stb,
        input logic enable,
        input logic full,
        input logic [15:0] addr,
        input logic [15:0] target
    );
        return stb && enable && !full && (addr == target);
    endfunction

    // Type bit high asks for the empty condition, low for not-full
    function automatic logic type_hit(
        input logic type_sel,
        input logic empty,
        input logic full
    );
        return type_sel ? empty : !full;
    endfunction

    // Divided converter clock as an enable pulse
    assign conv_tick = (div_q == CLOCK_DIVIDE_FIELD); // see RL2
    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            div_q <= adf_pkg::DIV_RESET;
        end else if (conv_tick || !MODULE_ENABLE) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            phase_q <= '0;
        end else if (!MODULE_ENABLE) begin
            phase_q <= '0;
        end else if (conv_tick) begin
            phase_q <= (phase_q == CW'(CLKS_PER_SAMPLE-1)) ? '0 : phase_q + 1'b1; // see RL1
        end
    end
    assign sample_now = MODULE_ENABLE && conv_tick && (phase_q == CW'(CLKS_PER_SAMPLE-1));

    // Writes land only when enabled and not full; refused words leave no trace
    assign l_push = accepts(LINK.wr_stb, MODULE_ENABLE, l_full, LINK.wr_addr,
        adf_pkg::LEFT_SAMPLE_IN_ADDR); // see RL10, RL14
    assign r_push = accepts(LINK.wr_stb, MODULE_ENABLE, r_full, LINK.wr_addr,
        adf_pkg::RIGHT_SAMPLE_IN_ADDR); // see RL10, RL13

    adf_fifo #(
        .WIDTH(SW),
        .DEPTH(DEPTH)
    ) u_left (
        .clk(REF_CLK),
        .rst_b(RST_B),
        .push(l_push),
        .push_data(LINK.wr_data),
        .pop(sample_now),
        .head(l_head),
        .full(l_full),
        .empty(l_empty)
    );

    adf_fifo #(
        .WIDTH(SW),
        .DEPTH(DEPTH)
    ) u_right (
        .clk(REF_CLK),
        .rst_b(RST_B),
        .push(r_push),
        .push_data(LINK.wr_data),
        .pop(sample_now),
        .head(r_head),
        .full(r_full),
        .empty(r_empty)
    );

    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            SAMPLE_VALID <= 1'b0;
        end else begin
            SAMPLE_VALID <= sample_now; // see RL5
        end
    end

    // Both channels are taken on the same tick so the stereo pair stays aligned
    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            LEFT_SAMPLE <= '0;
        end else if (sample_now) begin
            LEFT_SAMPLE <= l_empty ? DEFAULT_SAMPLE : l_head; // see RL8
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            RIGHT_SAMPLE <= '0;
        end else if (sample_now) begin
            RIGHT_SAMPLE <= r_empty ? DEFAULT_SAMPLE : r_head; // see RL8
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            LEFT_SAMPLE_SIGNED <= 1'b0;
        end else begin
            LEFT_SAMPLE_SIGNED <= DATA_FORMAT_SIGNED; // see RL16
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            CHANNEL_STATUS <= status_word(1'b0, 1'b1, 1'b0, 1'b1);
        end else begin
            CHANNEL_STATUS <= status_word(l_full, l_empty, r_full, r_empty); // see RL6
        end
    end

    // Reset value matches the idle enable level, so no false rise after reset
    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            en_q <= 1'b0;
        end else begin
            en_q <= MODULE_ENABLE;
        end
    end

    // Evaluate one cycle after the pop so the FIFO state has settled
    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            eval_q <= 1'b0;
        end else begin
            eval_q <= sample_now;
        end
    end

    // Enabling onto an empty FIFO asks for data whatever the type bit says
    assign enable_rise = MODULE_ENABLE && !en_q; // see RL7

    // Left request: hardware set beats the clear from the writer
    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            l_req_q <= 1'b0;
        end else if ((enable_rise && l_empty) // see RL7
            || (eval_q && type_hit(LEFT_IRQ_TYPE_SEL, l_empty, l_full))) begin // see RL4, RL15
            l_req_q <= 1'b1; // see RL5
        end else if (LINK.left_req_clr) begin
            l_req_q <= 1'b0; // see RL11
        end
    end

    // Right request: same policy, kept apart so each channel stands alone
    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            r_req_q <= 1'b0;
        end else if ((enable_rise && r_empty) // see RL7
            || (eval_q && type_hit(RIGHT_IRQ_TYPE_SEL, r_empty, r_full))) begin // see RL4, RL15
            r_req_q <= 1'b1; // see RL5
        end else if (LINK.right_req_clr) begin
            r_req_q <= 1'b0; // see RL11
        end
    end
    assign LINK.left_req = l_req_q; // see RL3
    assign LINK.right_req = r_req_q;
endmodule

// File: adf_pkg.sv
// Shared constants and types for the audio converter input FIFO control
// Operation
// RL1: One sample per channel every 256 converter clocks
// RL2: Converter clock is source divided by field plus one
// RL3: Separate left and right request outputs
// RL4: Per-channel type selects empty or not-full request
// RL5: Pop each FIFO every 256 clocks, then evaluate request
// RL6: Full and empty status bits at 9,8,1,0
// RL7: Enabling with empty FIFOs raises both requests
// RL8: Empty FIFO at read yields default sample
// RL9: Writer pushes one to four words per request
// RL10: Writes ignored when full or disabled
// RL11: Service routine clears flag before next request
// RL12: One DMA channel per converter channel
// RL13: Right request code 1001110, data at 0x03F6
// RL14: Left request code 1001111, data at 0x03F8
// RL15: Type bit one means empty, zero not-full
// RL16: Format bit one signed, zero unsigned
// RL17: Accepted write pushes word and updates flags
// RL18: Each FIFO is first-in first-out
package adf_pkg;
    localparam logic [15:0] RIGHT_SAMPLE_IN_ADDR = 16'h03F6;
    localparam logic [15:0] LEFT_SAMPLE_IN_ADDR = 16'h03F8;
    localparam logic [6:0] RIGHT_DMA_SEL = 7'h4E;
    localparam logic [6:0] LEFT_DMA_SEL = 7'h4F;
    localparam int CONV_CLKS_PER_SAMPLE = 256;
    localparam int FIFO_DEPTH = 4;
    localparam int SAMPLE_W = 16;
    localparam int DIV_W = 7;
    localparam int STAT_LEFT_FULL_BIT = 9;
    localparam int STAT_LEFT_EMPTY_BIT = 8;
    localparam int STAT_RIGHT_FULL_BIT = 1;
    localparam int STAT_RIGHT_EMPTY_BIT = 0;
    localparam int CTRL_ENABLE_BIT = 15;
    localparam logic [15:0] DEFAULT_SAMPLE_RESET = 16'h0000;
    localparam logic [DIV_W-1:0] DIV_RESET = 7'h00;
    typedef enum logic [1:0] {
        ADF_IDLE = 2'b01,
        ADF_WAIT = 2'b10
    } adf_wr_state_type;
endpackage

// File: adf_if.sv
// Peripheral write path and request lines between writer and converter
interface adf_if;
    logic wr_stb;
    logic [15:0] wr_addr;
    logic [15:0] wr_data;
    logic left_req;
    logic right_req;
    logic left_req_clr;
    logic right_req_clr;
    modport device (
        input wr_stb, wr_addr, wr_data, left_req_clr, right_req_clr,
        output left_req, right_req
    );
    modport host (
        output wr_stb, wr_addr, wr_data, left_req_clr, right_req_clr,
        input left_req, right_req
    );
endinterface

// File: adf_fifo.sv
// Four-word sample FIFO for one channel
module adf_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Push side
    input wire logic push,
    input wire logic [WIDTH-1:0] push_data,
    // Pop side
    input wire logic pop,
    output logic [WIDTH-1:0] head,
    output logic full,
    output logic empty
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0] cnt_q;
    logic do_push;
    logic do_pop;

    // Pointers wrap at the depth, which need not be a power of two
    function automatic logic [AW-1:0] ptr_next(input logic [AW-1:0] ptr);
        return (ptr == AW'(DEPTH-1)) ? '0 : ptr + 1'b1;
    endfunction

    assign full = (cnt_q == (AW+1)'(DEPTH));
    assign empty = (cnt_q == '0);
    assign head = mem[rp_q];
    assign do_push = push && !full;
    assign do_pop = pop && !empty;

    always_ff @(posedge clk) begin
        if (do_push) begin
            mem[wp_q] <= push_data; // see RL17
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (do_push) begin
                wp_q <= ptr_next(wp_q);
            end
            if (do_pop) begin
                rp_q <= ptr_next(rp_q); // see RL18
            end
            cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end
endmodule

// File: adf_host.sv
// Writer end: services each request with a burst of samples
module adf_host #(
    parameter int BURST = 1
) (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST_B,
    // Link to converter
    adf_if.host LINK,
    // User sample sources, one word per accepted take pulse
    input wire logic [15:0] LEFT_DATA,
    input wire logic [15:0] RIGHT_DATA,
    output logic LEFT_TAKE,
    output logic RIGHT_TAKE
);
    adf_pkg::adf_wr_state_type st_q;
    logic right_sel_q;
    logic [2:0] left_cnt_q;
    logic stb_q;
    logic [15:0] addr_q;
    logic [15:0] data_q;
    logic lclr_q, rclr_q;

    // Burst stays between one and the FIFO depth
    localparam logic [2:0] NB = 3'((BURST < 1) ? 1 :
        (BURST > adf_pkg::FIFO_DEPTH) ? adf_pkg::FIFO_DEPTH : BURST); // see RL9

    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            st_q <= adf_pkg::ADF_IDLE;
            right_sel_q <= 1'b0;
            left_cnt_q <= '0;
            stb_q <= 1'b0;
            addr_q <= '0;
            data_q <= '0;
            lclr_q <= 1'b0;
            rclr_q <= 1'b0;
            LEFT_TAKE <= 1'b0;
            RIGHT_TAKE <= 1'b0;
        end else begin
            stb_q <= 1'b0;
            lclr_q <= 1'b0;
            rclr_q <= 1'b0;
            LEFT_TAKE <= 1'b0;
            RIGHT_TAKE <= 1'b0;
            case (st_q)
                adf_pkg::ADF_IDLE: begin
                    if (LINK.left_req) begin
                        lclr_q <= 1'b1; // see RL11
                        right_sel_q <= 1'b0;
                        left_cnt_q <= NB;
                        st_q <= adf_pkg::ADF_WAIT;
                    end else if (LINK.right_req) begin
                        rclr_q <= 1'b1;
                        right_sel_q <= 1'b1;
                        left_cnt_q <= NB;
                        st_q <= adf_pkg::ADF_WAIT;
                    end
                end
                adf_pkg::ADF_WAIT: begin
                    if (left_cnt_q == '0) begin
                        st_q <= adf_pkg::ADF_IDLE;
                    end else begin
                        stb_q <= 1'b1; // see RL12
                        addr_q <= right_sel_q ? adf_pkg::RIGHT_SAMPLE_IN_ADDR
                            : adf_pkg::LEFT_SAMPLE_IN_ADDR; // see RL13, RL14
                        data_q <= right_sel_q ? RIGHT_DATA : LEFT_DATA;
                        LEFT_TAKE <= !right_sel_q;
                        RIGHT_TAKE <= right_sel_q;
                        left_cnt_q <= left_cnt_q - 3'h1;
                    end
                end
                default: st_q <= adf_pkg::ADF_IDLE;
            endcase
        end
    end
    assign LINK.wr_stb = stb_q;
    assign LINK.wr_addr = addr_q;
    assign LINK.wr_data = data_q;
    assign LINK.left_req_clr = lclr_q;
    assign LINK.right_req_clr = rclr_q;
endmodule

// File: adf_chk.sv
// Protocol checker for the write link and request lines
module adf_chk (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST_B,
    // Link
    input wire logic wr_stb,
    input wire logic [15:0] wr_addr,
    input wire logic left_req,
    input wire logic right_req,
    input wire logic left_req_clr,
    input wire logic right_req_clr
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] run_q;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);
    // Saturates so a runaway burst cannot wrap back to a legal count
    always_ff @(posedge REF_CLK) begin
        if (!RST_B || !wr_stb) begin
            run_q <= 3'h0;
        end else if (run_q != 3'h7) begin
            run_q <= run_q + 3'h1;
        end
    end
    sequence s_lserv;
        left_req_clr ##[1:4] (wr_stb && wr_addr == adf_pkg::LEFT_SAMPLE_IN_ADDR);
    endsequence
    sequence s_rserv;
        right_req_clr ##[1:4] (wr_stb && wr_addr == adf_pkg::RIGHT_SAMPLE_IN_ADDR);
    endsequence
    AST_LREQ_HOLD: assert property (left_req && !left_req_clr |=> left_req)
        else $error("left request dropped");
    AST_RREQ_HOLD: assert property (right_req && !right_req_clr |=> right_req)
        else $error("right request dropped");
    AST_LREQ_FALL: assert property ($fell(left_req) |-> $past(left_req_clr))
        else $error("left request fell unasked");
    AST_RREQ_FALL: assert property ($fell(right_req) |-> $past(right_req_clr))
        else $error("right request fell unasked");
    AST_LSERV: assert property ($rose(left_req) |-> ##[1:12] s_lserv)
        else $error("left request not serviced");
    AST_RSERV: assert property ($rose(right_req) |-> ##[1:12] s_rserv)
        else $error("right request not serviced");
    AST_ADDR: assert property (wr_stb |-> wr_addr inside {16'h03F6, 16'h03F8})
        else $error("write to a foreign address");
    AST_BURST: assert property (wr_stb |-> run_q < 3'h4)
        else $error("burst longer than the FIFO");
endmodule

// File: tb_top.sv
// Testbench: converter and writer face to face, plus a directly driven converter
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fail_count++; \
    $display("BAD %0t got %0h want %0h", $time, a, e); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic en_a = 1'b0;
    logic en_b = 1'b0;
    logic [6:0] div = 7'h00;
    logic ltype = 1'b1;
    logic rtype = 1'b0;
    logic fmt = 1'b0;
    logic [15:0] dflt = 16'h8000;
    logic [15:0] lsrc = 16'h1000;
    logic [15:0] rsrc = 16'h2000;
    logic [15:0] lexp = 16'h1000;
    logic [15:0] rexp = 16'h2000;
    logic ltake, rtake, va, vb, sgn;
    logic [15:0] sta, stb, lsa, rsa, lsb, rsb;
    int fail_count = 0;
    int comparisons = 0;
    int seen = 0;
    int n;
    adf_if link_a ();
    adf_if link_b ();
    always #12.5 clk = ~clk;
    adf_device #(.CLKS_PER_SAMPLE(8)) adf_device_i (.REF_CLK(clk), .RST_B(rst_b),
        .LINK(link_a.device), .MODULE_ENABLE(en_a), .CLOCK_DIVIDE_FIELD(div),
        .LEFT_IRQ_TYPE_SEL(ltype), .RIGHT_IRQ_TYPE_SEL(rtype), .DATA_FORMAT_SIGNED(fmt),
        .DEFAULT_SAMPLE(dflt), .CHANNEL_STATUS(sta), .LEFT_SAMPLE(lsa), .RIGHT_SAMPLE(rsa),
        .SAMPLE_VALID(va), .LEFT_SAMPLE_SIGNED(sgn));
    adf_device adf_device_solo_i (.REF_CLK(clk), .RST_B(rst_b), .LINK(link_b.device),
        .MODULE_ENABLE(en_b), .CLOCK_DIVIDE_FIELD(div), .LEFT_IRQ_TYPE_SEL(ltype),
        .RIGHT_IRQ_TYPE_SEL(rtype), .DATA_FORMAT_SIGNED(fmt), .DEFAULT_SAMPLE(dflt),
        .CHANNEL_STATUS(stb), .LEFT_SAMPLE(lsb), .RIGHT_SAMPLE(rsb), .SAMPLE_VALID(vb),
        .LEFT_SAMPLE_SIGNED());
    adf_host #(.BURST(1)) adf_host_i (.REF_CLK(clk), .RST_B(rst_b), .LINK(link_a.host),
        .LEFT_DATA(lsrc), .RIGHT_DATA(rsrc), .LEFT_TAKE(ltake), .RIGHT_TAKE(rtake));
    adf_chk adf_chk_i (.REF_CLK(clk), .RST_B(rst_b), .wr_stb(link_a.wr_stb),
        .wr_addr(link_a.wr_addr), .left_req(link_a.left_req), .right_req(link_a.right_req),
        .left_req_clr(link_a.left_req_clr), .right_req_clr(link_a.right_req_clr));
    always @(posedge clk) begin
        if (ltake) lsrc <= lsrc + 16'h0001;
        if (rtake) rsrc <= rsrc + 16'h0001;
    end
    // Supply gaps may show as default samples, never as reordering
    always @(negedge clk) begin
        if (rst_b && va === 1'b1) begin
            if (lsa !== dflt) begin
                `CHK(lsa, lexp)
                lexp = lexp + 16'h0001;
                seen++;
            end
            if (rsa !== dflt) begin
                `CHK(rsa, rexp)
                rexp = rexp + 16'h0001;
            end
        end
    end
    task automatic close_out();
        if (fail_count == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic wait_valid(input bit solo, output int k);
        k = 0;
        do begin
            @(negedge clk);
            k++;
            if (k > 2000) begin
                fail_count++;
                close_out();
            end
        end while ((solo ? vb : va) !== 1'b1);
    endtask
    task automatic put_b(input logic [15:0] addr, input logic [15:0] data);
        @(posedge clk);
        link_b.wr_stb <= 1'b1;
        link_b.wr_addr <= addr;
        link_b.wr_data <= data;
    endtask
    task automatic idle_b();
        @(posedge clk);
        link_b.wr_stb <= 1'b0;
        link_b.left_req_clr <= 1'b0;
        link_b.right_req_clr <= 1'b0;
    endtask
    task automatic t_refuse_disabled();
        @(negedge clk);
        `CHK(stb, 16'h0101)
        put_b(adf_pkg::LEFT_SAMPLE_IN_ADDR, 16'hAAAA);
        idle_b();
        repeat (2) @(negedge clk);
        `CHK(stb, 16'h0101)
    endtask
    task automatic t_enable();
        @(posedge clk) en_b <= 1'b1;
        repeat (2) @(negedge clk);
        `CHK({link_b.left_req, link_b.right_req}, 2'b11)
        @(posedge clk);
        link_b.left_req_clr <= 1'b1;
        link_b.right_req_clr <= 1'b1;
        idle_b();
        @(negedge clk);
        `CHK({link_b.left_req, link_b.right_req}, 2'b00)
    endtask
    task automatic t_fill_pop();
        for (int i = 0; i < 5; i++) put_b(adf_pkg::LEFT_SAMPLE_IN_ADDR, 16'h0A00 + 16'(i));
        put_b(adf_pkg::RIGHT_SAMPLE_IN_ADDR, 16'h0B00);
        put_b(16'h03F4, 16'h0C00);
        idle_b();
        repeat (2) @(negedge clk);
        `CHK(stb, 16'h0200)
        wait_valid(1'b1, n);
        `CHK({lsb, rsb}, 32'h0A000B00)
        repeat (3) @(negedge clk);
        `CHK({link_b.left_req, link_b.right_req}, 2'b01)
        `CHK(stb, 16'h0001)
        wait_valid(1'b1, n);
        // Three edges of the interval were spent on the checks above
        `CHK(n, adf_pkg::CONV_CLKS_PER_SAMPLE - 3)
        `CHK({lsb, rsb}, {16'h0A01, dflt})
        // Fifth word met a full FIFO, so default follows the fourth
        for (int i = 2; i < 5; i++) begin
            wait_valid(1'b1, n);
            `CHK(lsb, (i < 4) ? 16'h0A00 + 16'(i) : dflt)
        end
        // Left ran dry at its fourth pop, so the empty-type request stands
        `CHK(link_b.left_req, 1'b1)
    endtask
    task automatic t_format_div();
        @(posedge clk) fmt <= 1'b1;
        repeat (2) @(negedge clk);
        `CHK(sgn, 1'b1)
        `CHK(sta & 16'hFCFC, 16'h0000)
        for (int d = 0; d < 3; d++) begin
            @(posedge clk) div <= 7'(d);
            wait_valid(1'b0, n);
            wait_valid(1'b0, n);
            `CHK(n, 8 * (d + 1))
        end
    endtask
    initial begin
        link_b.wr_stb = 1'b0;
        link_b.wr_addr = 16'h0000;
        link_b.wr_data = 16'h0000;
        link_b.left_req_clr = 1'b0;
        link_b.right_req_clr = 1'b0;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk) en_a <= 1'b1;
        t_refuse_disabled();
        t_enable();
        t_fill_pop();
        t_format_div();
        `CHK(seen > 3, 1'b1)
        close_out();
    end
endmodule
